// ### rtl/fdio_drive_if.sv
// Drive-side interface logic: select gating, head load, write enable, read pulses
//
// Contract
// - No notch sensed drives write-protect output low.
// - Standard setup: read-only medium blocks writing regardless of write gate.
// - Read line carries raw flux pulses; controller separates clock and data.
// - Each read-data pulse is 1 us wide, within 250 ns; reversals under 1 us apart merge into one longer pulse.
// - Load-on-select closed: head loads when assigned select is active.
// - Load-on-motor closed: head loads when motor-on is active.
// - Single drive, multiplex closed: any select lights lamp, loads head.
// - Multiplex open, one select closed: respond only to assigned select.
// - Optional fourth select input allows four addressable drives.
// - Interface-only protect: status still reported, writing not blocked.
// - Write inhibit may come from a spare line instead of sensor.
// - Independent head load: head follows spare line only.
// - Option runs spindle motor from select instead of motor-on.
// - Lamp may follow motor-on or a chosen spare line instead.
// - Lamp on spare line depends on nothing else.
// - Select without head load by choosing load-on-motor.
// - Write, read, step, direction and protect paths gated by active-low select.
// - Low write gate writes; high write gate enables stepper and read data.
`timescale 1ns/1ps
`include "fdio_params.svh"

module fdio_drive_if (
  input  wire logic                           core_clk_i,       // 100 MHz clock
  input  wire logic                           srst_i,           // Sync reset, high
  input  wire logic                           clk_en_i,         // Freeze when low
  input  wire logic [`FDIO_SEL_W-1:0]         select_n_i,       // Select pins 0..3, low
  input  wire logic                           motor_on_n_i,     // Motor on pin, low
  input  wire logic                           write_gate_n_i,   // Write gate pin, low
  input  wire logic                           write_data_n_i,   // Composite write data
  input  wire logic                           step_n_i,         // Step pin, low
  input  wire logic                           direction_n_i,    // Direction pin
  input  wire logic [`FDIO_SPARE_W-1:0]       spare_n_i,        // Spare lines, low
  input  wire logic                           notch_seen_i,     // Sensor sees notch
  input  wire logic                           flux_pulse_i,     // Flux reversal seen
  input  wire logic [`FDIO_SEL_W-1:0]         select_shunt_position_i, // Closed pos.
  input  wire logic                           multiplex_shunt_position_i, // Closed
  input  wire logic                           fourth_unit_select_i, // Fourth select fit
  input  wire logic                           load_on_select_option_i, // Shunt closed
  input  wire logic                           load_on_motor_option_i,  // Shunt closed
  input  wire fdio_pkg::fdio_head_e           head_src_i,       // Head load source
  input  wire fdio_pkg::fdio_winh_e           winh_src_i,       // Inhibit source
  input  wire fdio_pkg::fdio_lamp_e           lamp_src_i,       // Lamp source
  input  wire logic                           motor_with_select_i, // Motor on select
  input  wire logic [`FDIO_SPARE_IDX_W-1:0]   winh_spare_idx_i, // Spare for inhibit
  input  wire logic [`FDIO_SPARE_IDX_W-1:0]   head_spare_idx_i, // Spare for head load
  input  wire logic [`FDIO_SPARE_IDX_W-1:0]   lamp_spare_idx_i, // Spare for lamp
  output logic                                write_protect_n_o, // Protect pin, low
  output logic                                read_data_n_o,    // Read data pin, low
  output logic                                head_load_o,      // Head solenoid
  output logic                                motor_run_o,      // Spindle motor
  output logic                                lamp_o,           // Front lamp
  output logic                                write_enable_o,   // Write current on
  output logic                                write_bit_o,      // Write data to head
  output logic                                step_o,           // Step to stepper
  output logic                                direction_o       // Direction to stepper
);
  import fdio_pkg::*;

  // ******************************************
  // Input synchronisers
  // ******************************************
  localparam int NIN = `FDIO_SEL_W + `FDIO_SPARE_W + 7;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic [NIN-1:0] sync3;
  logic [NIN-1:0] filt;

  assign raw_in = {~select_n_i, ~spare_n_i, ~motor_on_n_i, ~write_gate_n_i,
                   ~write_data_n_i, ~step_n_i, ~direction_n_i, notch_seen_i,
                   flux_pulse_i};

  // A change is taken once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          filt[gi]  <= 1'b0;
        end else if (clk_en_i) begin
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  wire [`FDIO_SEL_W-1:0]   sel_act   = filt[NIN-1 -: `FDIO_SEL_W];
  wire [`FDIO_SPARE_W-1:0] spare_act = filt[7 +: `FDIO_SPARE_W];
  wire motor_act  = filt[6];
  wire wgate_act  = filt[5];
  wire wdata_act  = filt[4];
  wire step_act   = filt[3];
  wire dir_act    = filt[2];
  wire notch      = filt[1];
  wire flux       = filt[0];

  // ******************************************
  // Select decode
  // ******************************************
  // fourth select fitting
  wire [`FDIO_SEL_W-1:0] sel_fit = {select_shunt_position_i[3:1],
                                    select_shunt_position_i[0] & fourth_unit_select_i};
  // only the assigned select line counts
  wire assigned_sel = |(sel_act & sel_fit);
  // multiplex closed: any select line counts
  wire any_sel = |{sel_act[3:1], sel_act[0] & fourth_unit_select_i};
  // write, read, step, direction and protect paths gated by select
  wire selected = multiplex_shunt_position_i ? any_sel : assigned_sel;

  // ******************************************
  // Head load, motor, lamp
  // ******************************************
  wire head_spare  = spare_act[head_spare_idx_i];
  wire lamp_spare  = spare_act[lamp_spare_idx_i];
  wire winh_spare  = spare_act[winh_spare_idx_i];
  wire motor_src   = motor_with_select_i ? selected : motor_act;
  // load on select; load on motor only
  wire head_shunt  = (load_on_select_option_i & selected) |
                     (load_on_motor_option_i & motor_act);
  // independent head load from spare line only
  wire next_head   = (head_src_i == FDIO_HEAD_SPARE) ? head_spare : head_shunt;
  logic next_lamp;
  always_comb begin
    case (lamp_src_i)
      FDIO_LAMP_SELECT: next_lamp = selected;
      FDIO_LAMP_MOTOR:  next_lamp = motor_act;
      FDIO_LAMP_SPARE:  next_lamp = lamp_spare;
      default:          next_lamp = selected;
    endcase
  end

  // ******************************************
  // Write path
  // ******************************************
  // read-only medium when no notch
  wire protected_med = ~notch;
  logic inhibit;
  always_comb begin
    case (winh_src_i)
      FDIO_WINH_SENSOR: inhibit = protected_med;
      FDIO_WINH_NONE:   inhibit = 1'b0;
      FDIO_WINH_SPARE:  inhibit = winh_spare;
      default:          inhibit = protected_med;
    endcase
  end
  wire next_wen = selected & wgate_act & ~inhibit;
  // read and stepper only with write gate high
  wire read_ok  = selected & ~wgate_act;

  // ******************************************
  // Read pulse stretcher
  // ******************************************
  // Flux edges are passed raw; pulses closer than the width merge, a
  // limitation accepted since encoded cells are several microseconds apart
  localparam logic [`FDIO_CNT_W-1:0] RD_CYC = `FDIO_CNT_W'(`FDIO_RD_PULSE_CYC);
  logic [`FDIO_CNT_W-1:0] rd_cnt;
  logic                   flux_d;
  wire flux_rise = flux & ~flux_d;

  // a full-width pulse from each flux reversal; a reversal within a pulse restarts it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_cnt <= '0;
      flux_d <= 1'b0;
    end else if (clk_en_i) begin
      flux_d <= flux;
      if (flux_rise && read_ok) begin
        rd_cnt <= RD_CYC;
      end else if (rd_cnt != '0) begin
        rd_cnt <= rd_cnt - `FDIO_CNT_W'(1);
      end
    end
  end

  // ******************************************
  // Output registers
  // ******************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      write_protect_n_o <= 1'b1;
      read_data_n_o     <= 1'b1;
      head_load_o       <= 1'b0;
      motor_run_o       <= 1'b0;
      lamp_o            <= 1'b0;
      write_enable_o    <= 1'b0;
      write_bit_o       <= 1'b0;
      step_o            <= 1'b0;
      direction_o       <= 1'b0;
    end else if (clk_en_i) begin
      write_protect_n_o <= ~(selected & protected_med);
      read_data_n_o     <= ~(read_ok & (rd_cnt != '0));
      head_load_o       <= next_head;
      motor_run_o       <= motor_src;
      lamp_o            <= next_lamp;
      write_enable_o    <= next_wen;
      write_bit_o       <= next_wen & wdata_act;
      step_o            <= read_ok & step_act;
      direction_o       <= read_ok & dir_act;
    end
  end

  // ******************************************
  // Checks
  // ******************************************
  a_wen_needs_sel: assert property (@(posedge core_clk_i) disable iff (srst_i)
    write_enable_o |-> $past(selected) && $past(wgate_act))
    else $error("write enabled without select and gate");
  a_protect_blocks: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && winh_src_i == FDIO_WINH_SENSOR && protected_med) |=> !write_enable_o)
    else $error("write enabled on protected medium");
  a_protect_report: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && selected && protected_med) |=> !write_protect_n_o)
    else $error("protect not reported");
  a_iface_only: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && winh_src_i == FDIO_WINH_NONE && selected && wgate_act) |=> write_enable_o)
    else $error("interface-only protect blocked write");
  a_rd_width: assert property (@(posedge core_clk_i) disable iff (srst_i || !clk_en_i)
    (rd_cnt == RD_CYC) |-> (rd_cnt != '0) [*8])
    else $error("read pulse too short");
  a_rd_gated: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !read_data_n_o |-> $past(read_ok))
    else $error("read data driven while writing or unselected");
  a_head_spare: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && head_src_i == FDIO_HEAD_SPARE) |=> head_load_o == $past(head_spare))
    else $error("independent head load wrong");
  a_lamp_spare: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && lamp_src_i == FDIO_LAMP_SPARE) |=> lamp_o == $past(lamp_spare))
    else $error("lamp not following spare line");
  a_unsel_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && !selected) |=> (write_protect_n_o && !step_o && !write_enable_o))
    else $error("outputs active while unselected");

  // ******************************************
  // Option checks
  // ******************************************
  a_motor_select: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && motor_with_select_i) |=> motor_run_o == $past(selected))
    else $error("motor not following select");

  a_motor_pin: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && !motor_with_select_i) |=> motor_run_o == $past(motor_act))
    else $error("motor not following motor-on");

  a_head_select: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && head_src_i != FDIO_HEAD_SPARE && load_on_select_option_i && selected)
    |=> head_load_o)
    else $error("head not loaded on select");

  a_head_motor: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && head_src_i != FDIO_HEAD_SPARE && load_on_motor_option_i && motor_act)
    |=> head_load_o)
    else $error("head not loaded on motor-on");

  a_head_motor_only: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && head_src_i != FDIO_HEAD_SPARE && !load_on_select_option_i && !motor_act)
    |=> !head_load_o)
    else $error("head loaded without motor-on");

  a_lamp_motor: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && lamp_src_i == FDIO_LAMP_MOTOR) |=> lamp_o == $past(motor_act))
    else $error("lamp not following motor-on");

  a_lamp_select: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && lamp_src_i == FDIO_LAMP_SELECT) |=> lamp_o == $past(selected))
    else $error("lamp not following select");

  a_mux_any: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && multiplex_shunt_position_i && any_sel &&
     lamp_src_i == FDIO_LAMP_SELECT) |=> lamp_o)
    else $error("any select did not light lamp");

  a_assigned_only: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && !multiplex_shunt_position_i && !assigned_sel)
    |=> (!write_enable_o && !step_o))
    else $error("responded to a foreign select");

  a_fourth_unfit: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (!fourth_unit_select_i && sel_act == 4'h1) |-> !selected)
    else $error("unfitted fourth select took effect");

  a_fourth_used: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (fourth_unit_select_i && multiplex_shunt_position_i && sel_act[0]) |-> selected)
    else $error("fitted fourth select ignored");

  a_winh_spare: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && winh_src_i == FDIO_WINH_SPARE && winh_spare) |=> !write_enable_o)
    else $error("spare inhibit did not block write");

  a_wbit_gated: assert property (@(posedge core_clk_i) disable iff (srst_i)
    write_bit_o |-> write_enable_o)
    else $error("write data without write enable");

  a_wbit_data: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && next_wen && wdata_act) |=> write_bit_o)
    else $error("write data not passed");

  a_rd_stream: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && flux_rise && read_ok) |=> rd_cnt == RD_CYC)
    else $error("flux reversal not passed on");

  a_rd_count_down: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && rd_cnt != '0 && !(flux_rise && read_ok))
    |=> rd_cnt == $past(rd_cnt) - `FDIO_CNT_W'(1))
    else $error("read pulse counter skipped");

  a_step_gated: assert property (@(posedge core_clk_i) disable iff (srst_i)
    step_o |-> $past(read_ok))
    else $error("step passed while writing");

  a_dir_gated: assert property (@(posedge core_clk_i) disable iff (srst_i)
    direction_o |-> $past(read_ok))
    else $error("direction passed while writing");

  a_rd_unsel: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && !selected) |=> read_data_n_o)
    else $error("read data while unselected");

  a_wen_on_gate: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && selected && wgate_act && !inhibit) |=> write_enable_o)
    else $error("write enable missing");

  a_wen_inhibit: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && inhibit) |=> !write_enable_o)
    else $error("write enabled while inhibited");

  a_wp_writable: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (clk_en_i && !protected_med) |=> write_protect_n_o)
    else $error("protect reported on writable medium");

endmodule

// ### rtl/fdio_params.svh
// Constants of the drive interface option logic
`ifndef FDIO_PARAMS_SVH
`define FDIO_PARAMS_SVH
`define FDIO_CLK_PERIOD_NS   10
`define FDIO_RD_PULSE_NS     1000
`define FDIO_RD_PULSE_CYC    (`FDIO_RD_PULSE_NS / `FDIO_CLK_PERIOD_NS)
`define FDIO_CNT_W           8
`define FDIO_SEL_W           4
`define FDIO_LAMP_SEL_W      2
`define FDIO_SPARE_W         5
`define FDIO_SPARE_IDX_W     3
`endif

// ### rtl/fdio_pkg.sv
// Types of the drive interface option logic
package fdio_pkg;
  typedef enum logic [1:0] {
    FDIO_LAMP_SELECT,
    FDIO_LAMP_MOTOR,
    FDIO_LAMP_SPARE
  } fdio_lamp_e;
  typedef enum logic [1:0] {
    FDIO_HEAD_ON_SELECT,
    FDIO_HEAD_ON_MOTOR,
    FDIO_HEAD_SPARE
  } fdio_head_e;
  typedef enum logic [1:0] {
    FDIO_WINH_SENSOR,
    FDIO_WINH_NONE,
    FDIO_WINH_SPARE
  } fdio_winh_e;
endpackage

// ### testbench/fdio_ctrl_model.sv
// Controller-side model that produces the composite write data stream
`timescale 1ns/1ps
module fdio_ctrl_model (
  input  wire logic core_clk_i,     // 100 MHz clock
  input  wire logic srst_i,         // Sync reset, high
  input  wire logic data_bit_i,     // Bit to encode in this cell
  output logic      write_data_n_o  // Composite write data, low pulses
);
  int cnt;
  // exact 8 us cell, data at 4 us
  // pulses 500 ns, inside 250 ns to 2.1 us
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt <= 0;
      write_data_n_o <= 1'b1;
    end else begin
      cnt <= (cnt == 799) ? 0 : cnt + 1;
      write_data_n_o <= !((cnt < 50) || (data_bit_i && cnt >= 400 && cnt < 450));
    end
  end
endmodule

// ### testbench/floppy_drive_interface_options_tb_top.sv
// Self-checking bench of the drive interface option logic
`timescale 1ns/1ps
`include "fdio_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module floppy_drive_interface_options_tb_top;
  import fdio_pkg::*;
  logic       clk = 1'b0, srst = 1'b1, mot_n = 1'b1, wg_n = 1'b1, stp_n = 1'b1, dir_n = 1'b1;
  logic       notch = 1'b1, flux = 1'b0, mux = 1'b1, fourth = 1'b0, los = 1'b1, lom = 1'b0;
  logic       mws = 1'b0, dbit = 1'b0, cen = 1'b1, dir;
  logic [3:0] sel_n = 4'hF, shunt = 4'hF;
  logic [4:0] spare_n = 5'h1F;
  logic [2:0] wi_idx = 3'h0, hd_idx = 3'h0, lp_idx = 3'h0;
  fdio_head_e hsrc = FDIO_HEAD_ON_SELECT;
  fdio_winh_e wsrc = FDIO_WINH_SENSOR;
  fdio_lamp_e lsrc = FDIO_LAMP_SELECT;
  logic       wd_n, wp_n, rd_n, head, motor, lamp, we, wbit, stp;
  int         error_cnt = 0, cmp_count = 0, seed = 72, low_cnt = 0;
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (rd_n === 1'b0) low_cnt++;
  fdio_ctrl_model PEER (.core_clk_i(clk), .srst_i(srst), .data_bit_i(dbit), .write_data_n_o(wd_n));
  fdio_drive_if DUT (.core_clk_i(clk), .srst_i(srst), .clk_en_i(cen), .select_n_i(sel_n),
    .motor_on_n_i(mot_n), .write_gate_n_i(wg_n), .write_data_n_i(wd_n), .step_n_i(stp_n),
    .direction_n_i(dir_n), .spare_n_i(spare_n), .notch_seen_i(notch), .flux_pulse_i(flux),
    .select_shunt_position_i(shunt), .multiplex_shunt_position_i(mux),
    .fourth_unit_select_i(fourth), .load_on_select_option_i(los), .load_on_motor_option_i(lom),
    .head_src_i(hsrc), .winh_src_i(wsrc), .lamp_src_i(lsrc), .motor_with_select_i(mws),
    .winh_spare_idx_i(wi_idx), .head_spare_idx_i(hd_idx), .lamp_spare_idx_i(lp_idx),
    .write_protect_n_o(wp_n), .read_data_n_o(rd_n), .head_load_o(head), .motor_run_o(motor),
    .lamp_o(lamp), .write_enable_o(we), .write_bit_o(wbit), .step_o(stp), .direction_o(dir));
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  // Reference model of the level outputs, from the pins and option straps
  task automatic check_levels();
    logic [3:0] act;
    bit s, inh, h, l, e;
    act = ~sel_n & {3'b111, fourth};
    s = mux ? |act : |(act & shunt);
    inh = (wsrc == FDIO_WINH_SENSOR) ? !notch : (wsrc == FDIO_WINH_SPARE) ? !spare_n[wi_idx] : 0;
    h = (hsrc == FDIO_HEAD_SPARE) ? !spare_n[hd_idx] : (los && s) || (lom && !mot_n);
    l = (lsrc == FDIO_LAMP_SELECT) ? s : (lsrc == FDIO_LAMP_MOTOR) ? !mot_n : !spare_n[lp_idx];
    e = s && !wg_n && !inh;
    `CHK("write_protect_n", !(s && !notch), wp_n)
    `CHK("head_load", h, head)
    `CHK("lamp", l, lamp)
    `CHK("motor_run", mws ? s : !mot_n, motor)
    `CHK("write_enable", e, we)
    `CHK("step", s && wg_n && !stp_n, stp)
    `CHK("direction", s && wg_n && !dir_n, dir)
    if (!e) `CHK("write_bit", 1'b0, wbit)
  endtask
  task automatic flux_hit();
    @(posedge clk) flux <= 1'b1;
    cyc(3);
    flux <= 1'b0;
  endtask
  // One flux edge, or two merged edges gap cycles apart
  task automatic read_pulse(int gap, int exp_low);
    low_cnt = 0;
    flux_hit();
    if (gap > 0) begin
      cyc(gap - 4);
      flux_hit();
    end
    cyc(300);
    `CHK("read_low_cycles", exp_low, low_cnt)
  endtask
  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    cyc(3);
    srst <= 1'b0;
    cyc(2);
    // Random pin levels and straps; select 0 stays idle when any select is taken
    repeat (300) begin
      @(posedge clk);
      {mot_n, wg_n, stp_n, dir_n, notch, mux, fourth, los, lom, mws, dbit} <= 11'($random(seed));
      sel_n <= 4'($random(seed));
      shunt <= 4'($random(seed));
      spare_n <= 5'($random(seed));
      wi_idx <= 3'($unsigned($random(seed)) % 5);
      hd_idx <= 3'($unsigned($random(seed)) % 5);
      lp_idx <= 3'($unsigned($random(seed)) % 5);
      hsrc <= fdio_head_e'(2'($unsigned($random(seed)) % 3));
      wsrc <= fdio_winh_e'(2'($unsigned($random(seed)) % 3));
      lsrc <= fdio_lamp_e'(2'($unsigned($random(seed)) % 3));
      cyc(1);
      if (mux) sel_n[0] <= 1'b1;
      cyc(8);
      check_levels();
    end
    // Clock enable low must hold the lamp although its spare line moves
    lsrc <= FDIO_LAMP_SPARE;
    lp_idx <= 3'h0;
    cyc(8);
    cen <= 1'b0;
    spare_n[0] <= ~spare_n[0];
    cyc(10);
    `CHK("lamp_frozen", spare_n[0], lamp)
    cen <= 1'b1;
    cyc(8);
    check_levels();
    // Read pulses: selected, write gate high, then blocked cases
    {mux, fourth, mot_n, stp_n} <= 4'hB;
    sel_n <= 4'hD;
    wg_n <= 1'b1;
    cyc(8);
    read_pulse(0, `FDIO_RD_PULSE_CYC);
    read_pulse(50, 50 + `FDIO_RD_PULSE_CYC);
    wg_n <= 1'b0;
    cyc(8);
    read_pulse(0, 0);
    {wg_n, sel_n} <= 5'h1F;
    cyc(8);
    read_pulse(0, 0);
    summarize();
  end
endmodule
